/* File: match_channel.sv */
// one match register with holding value, release latch and active comparator value
`timescale 1ns/100ps
module match_channel (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // software side
    input wire logic writeEn,
    input wire logic [31:0] writeData,
    input wire logic releaseEn,
    // transfer control
    input wire logic periodLoad,
    input wire logic immediateLoad,
    // comparator value
    output logic [31:0] activeValue
);
    typedef struct packed {
        logic [31:0] hold;
        logic pending;
        logic [31:0] active;
    } chan_s;

    chan_s cur_q;
    chan_s nxt_d;

    // holding value, release flag and transfer into the comparator
    always_comb begin
        logic xfer;
        xfer = 1'b0;
        nxt_d = cur_q;
        if (writeEn) begin
            nxt_d.hold = writeData;
        end
        xfer = cur_q.pending & (periodLoad | immediateLoad);
        if (xfer) begin
            nxt_d.active = cur_q.hold;
        end
        // a release in the transfer cycle is kept
        nxt_d.pending = releaseEn | (cur_q.pending & ~xfer);
    end

    // state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    assign activeValue = cur_q.active;
endmodule

/* File: match_pwm_timer.sv */
// match based pulse width modulator on a prescaled 32-bit timer/counter
//
// Behaviour
// - seven match registers serve up to six single or three double edge outputs
// - period match clears the count, giving all outputs one repetition rate
// - single edge output rises at period match, falls at its own match
// - double edge output uses two matches, rise and fall anywhere in cycle
// - rise before fall gives positive pulse, fall first gives negative pulse
// - new match values take effect only after release, in step with outputs
// - each match may continue, stop or clear the count, and flag an event
// - 32-bit counter advances when the programmable 32-bit prescaler expires
// - count source is the clock or edges of a chosen capture input
// - with pulse mode off the block is a plain timer, outputs stay low
// - a slave instance counts only while its master runs, for lock-step use
// - period and width are any whole number of counts
`timescale 1ns/100ps
module match_pwm_timer (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // counter control
    input wire logic counterEnable,
    input wire logic counterReset,
    input wire logic pwmEnable,
    input wire logic [31:0] prescaleLimit,
    // count source
    input wire logic counterMode,
    input wire logic [1:0] captureSelect,
    input wire logic [1:0] captureEdge,
    input wire logic [3:0] captureIn,
    // match register access
    input wire logic [6:0] matchWrite,
    input wire logic [31:0] matchWriteData,
    input wire logic [6:0] matchRelease,
    // match actions
    input wire logic [6:0] matchResetEn,
    input wire logic [6:0] matchStopEn,
    input wire logic [6:0] matchEventEn,
    // output configuration
    input wire logic [6:1] doubleEdgeSel,
    input wire logic [6:1] outputEnable,
    // lock-step
    input wire logic slaveMode,
    input wire logic masterRunning,
    // status and outputs
    output logic [31:0] countValue,
    output logic [31:0] prescaleValue,
    output logic [6:0] matchEvent,
    output logic counterStopped,
    output logic runningOut,
    output logic [6:1] pulseOut
);
    typedef struct packed {
        logic [3:0] capMeta;
        logic [3:0] capSync;
        logic [3:0] capPrev;
        logic [31:0] prescale;
        logic [31:0] count;
        logic stopped;
        logic running;
        logic [6:0] event_;
        logic [6:1] pulse;
    } timer_s;

    timer_s cur_q;
    timer_s nxt_d;
    logic [31:0] activeMatch [pwm_timer_pkg::MatchCount];
    logic periodLoad;
    logic immediateLoad;

    ////////////////////////////////////////////////////////////////////////////////
    // match registers
    genvar gi;
    generate
        for (gi = 0; gi < pwm_timer_pkg::MatchCount; gi++) begin : g_match
            match_channel u_chan (
                .sys_clk(sys_clk),
                .rstn(rstn),
                .writeEn(matchWrite[gi]),
                .writeData(matchWriteData),
                .releaseEn(matchRelease[gi]),
                .periodLoad(periodLoad),
                .immediateLoad(immediateLoad),
                .activeValue(activeMatch[gi])
            );
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // count tick, matches and outputs
    logic runEnable;
    logic srcTick;
    logic advance;
    logic selSync;
    logic selPrev;
    logic [6:0] hit;
    logic [6:1] setOut;
    logic [6:1] clrOut;

    // lock-step gating for slave use
    assign runEnable = counterEnable & (~slaveMode | masterRunning) & ~cur_q.stopped;
    assign selSync = cur_q.capSync[captureSelect];
    assign selPrev = cur_q.capPrev[captureSelect];

    // count source: every clock or a capture edge
    always_comb begin
        srcTick = 1'b1;
        if (counterMode) begin
            case (captureEdge)
                pwm_timer_pkg::EdgeRising: srcTick = selSync & ~selPrev;
                pwm_timer_pkg::EdgeFalling: srcTick = ~selSync & selPrev;
                pwm_timer_pkg::EdgeBoth: srcTick = selSync ^ selPrev;
                default: srcTick = 1'b0;
            endcase
        end
    end

    // counter advances when the prescaler has run its full length
    assign advance = runEnable & ~counterReset & srcTick
        & (cur_q.prescale == prescaleLimit);

    // comparator hits, taken at the advance
    always_comb begin
        for (int i = 0; i < pwm_timer_pkg::MatchCount; i++) begin
            hit[i] = advance & (cur_q.count == activeMatch[i]);
        end
    end

    // transfer of released values: at period match in pulse mode, else at once
    assign periodLoad = pwmEnable & hit[pwm_timer_pkg::PeriodMatch];
    assign immediateLoad = ~pwmEnable;

    // set and clear terms of each output
    always_comb begin
        for (int n = 1; n <= pwm_timer_pkg::OutputCount; n++) begin
            if (doubleEdgeSel[n] && n > 1) begin
                setOut[n] = hit[n-1];
                clrOut[n] = hit[n];
            end else begin
                setOut[n] = hit[pwm_timer_pkg::PeriodMatch];
                clrOut[n] = hit[n];
            end
        end
    end

    // next state
    always_comb begin
        logic clearCount;
        logic stopCount;
        clearCount = 1'b0;
        stopCount = 1'b0;
        nxt_d = cur_q;
        nxt_d.capMeta = captureIn;
        nxt_d.capSync = cur_q.capMeta;
        nxt_d.capPrev = cur_q.capSync;
        for (int i = 0; i < pwm_timer_pkg::MatchCount; i++) begin
            if (hit[i] && matchResetEn[i]) begin
                clearCount = 1'b1;
            end
            if (hit[i] && matchStopEn[i]) begin
                stopCount = 1'b1;
            end
        end
        if (periodLoad) begin
            clearCount = 1'b1;
        end
        // prescaler
        if (counterReset) begin
            nxt_d.prescale = pwm_timer_pkg::CountZero;
        end else if (runEnable && srcTick) begin
            if (advance) begin
                nxt_d.prescale = pwm_timer_pkg::CountZero;
            end else begin
                nxt_d.prescale = cur_q.prescale + pwm_timer_pkg::CountOne;
            end
        end
        // timer/counter
        if (counterReset) begin
            nxt_d.count = pwm_timer_pkg::CountZero;
        end else if (advance) begin
            if (clearCount) begin
                nxt_d.count = pwm_timer_pkg::CountZero;
            end else begin
                nxt_d.count = cur_q.count + pwm_timer_pkg::CountOne;
            end
        end
        // stop holds until the enable is dropped
        if (stopCount) begin
            nxt_d.stopped = 1'b1;
        end else if (!counterEnable) begin
            nxt_d.stopped = 1'b0;
        end
        nxt_d.running = runEnable & ~stopCount;
        nxt_d.event_ = hit & matchEventEn;
        // outputs: clear wins, so an edge match equal to the period gives constant low
        for (int n = 1; n <= pwm_timer_pkg::OutputCount; n++) begin
            if (!pwmEnable || !outputEnable[n]) begin
                nxt_d.pulse[n] = 1'b0;
            end else if (clrOut[n]) begin
                nxt_d.pulse[n] = 1'b0;
            end else if (setOut[n]) begin
                nxt_d.pulse[n] = 1'b1;
            end
        end
    end

    // state register
    always_ff @(posedge sys_clk or negedge rstn) begin
        if (!rstn) begin
            cur_q <= '0;
        end else begin
            cur_q <= nxt_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs straight from flip-flops
    assign countValue = cur_q.count;
    assign prescaleValue = cur_q.prescale;
    assign matchEvent = cur_q.event_;
    assign counterStopped = cur_q.stopped;
    assign runningOut = cur_q.running;
    assign pulseOut = cur_q.pulse;
endmodule

/* File: match_pwm_timer_checker.sv */
// assertions for the match based pulse timer
`timescale 1ns/100ps
module match_pwm_timer_checker (
    // clock and reset
    input wire logic sys_clk,
    input wire logic rstn,
    // watched inputs
    input wire logic counterReset,
    input wire logic pwmEnable,
    input wire logic [31:0] prescaleLimit,
    input wire logic [6:0] matchStopEn,
    input wire logic [6:0] matchEventEn,
    input wire logic slaveMode,
    input wire logic masterRunning,
    // watched outputs
    input wire logic [31:0] countValue,
    input wire logic [31:0] prescaleValue,
    input wire logic [6:0] matchEvent,
    input wire logic counterStopped,
    input wire logic [6:1] pulseOut
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    // pulse mode held over two edges
    sequence s_pwm_steady;
        pwmEnable && $past(pwmEnable);
    endsequence
    // count moved without being cleared
    sequence s_advance;
        $changed(countValue) && countValue != 32'h0;
    endsequence
    a_timer_quiet: assert property (!pwmEnable |=> pulseOut == 6'h00)
        else $error("pulse output outside pulse mode");
    a_event_gated: assert property ((matchEvent & ~$past(matchEventEn)) == 7'h00)
        else $error("event from a disabled match");
    a_count_prescale: assert property (s_advance |-> $past(prescaleValue) == $past(prescaleLimit))
        else $error("count moved before prescaler expiry");
    a_reset_hold: assert property (counterReset |=> countValue == 32'h0 && prescaleValue == 32'h0)
        else $error("counter not held by reset input");
    a_period_rise: assert property (s_pwm_steady ##0 $rose(pulseOut[1]) |-> countValue == 32'h0)
        else $error("single edge rise away from period start");
    a_slave_hold: assert property (slaveMode && !masterRunning && !counterReset |=> $stable(countValue))
        else $error("slave counted with master idle");
    a_stop_hold: assert property (counterStopped && !counterReset |=> $stable(countValue))
        else $error("stopped counter moved");
    a_stop_event: assert property ($rose(counterStopped) && $past(matchEventEn) == $past(matchStopEn)
        |-> (matchEvent & $past(matchStopEn)) != 7'h00)
        else $error("stop without its match event");
endmodule
bind match_pwm_timer match_pwm_timer_checker match_pwm_timer_checker_i (.*);

/* File: motor_load.sv */
// tachometer feedback of a motor stage
`timescale 1ns/100ps
module motor_load (
    // clock
    input wire logic sys_clk,
    // rotor turning
    input wire logic spin,
    // feedback pins
    output logic [3:0] tach
);
    logic [2:0] phase;
    initial begin
        phase = 3'h0;
        tach = 4'h0;
    end
    // sensor toggles every four clocks, spare lines never sit still
    always @(posedge sys_clk) begin
        phase <= phase + 3'h1;
        if (spin && phase[1:0] == 2'h3) tach[0] <= ~tach[0];
        tach[3:1] <= phase;
    end
endmodule

/* File: pwm_timer_pkg.sv */
// constants shared by the match based pulse timer
package pwm_timer_pkg;
    localparam int CountWidth = 32;
    localparam int MatchCount = 7;
    localparam int OutputCount = 6;
    localparam int CaptureCount = 4;
    localparam logic [CountWidth-1:0] CountZero = 32'h0000_0000;
    localparam logic [CountWidth-1:0] CountOne = 32'h0000_0001;
    localparam int PeriodMatch = 0;
    // capture edge choice for counter operation
    typedef enum logic [1:0] {
        EdgeRising = 2'h0,
        EdgeFalling = 2'h1,
        EdgeBoth = 2'h3
    } capture_edge_e;
endpackage

/* File: test_match_pwm_timer.sv */
// self-checking bench for the match based pulse timer
`timescale 1ns/100ps
module test_match_pwm_timer;
    logic sys_clk, rstn, counterEnable, counterReset, pwmEnable, counterMode;
    logic slaveMode, masterRunning, spin, counterStopped, runningOut;
    logic [31:0] prescaleLimit, matchWriteData, countValue, prescaleValue;
    logic [6:0] matchWrite, matchRelease, matchResetEn, matchStopEn, matchEventEn, matchEvent;
    logic [6:1] doubleEdgeSel, outputEnable, pulseOut, lastPulse;
    logic [3:0] captureIn;
    logic [1:0] captureSelect, captureEdge;
    logic [31:0] tbl[6];
    logic [44:0] notes[$];
    int failures, checks, seed;
    match_pwm_timer match_pwm_timer_i (.*);
    motor_load motor_load_i (.sys_clk(sys_clk), .spin(spin), .tach(captureIn));
    ////////////////////////////////////////////////////////////
    task chk(input logic [44:0] seen, input logic [44:0] want, input string what);
        checks++;
        if (seen !== want) begin
            failures++;
            $display("Error %s expected %h seen %h", what, want, seen);
        end
    endtask
    task finish_test;
        $display("checks %0d failures %0d", checks, failures);
        if (failures == 0 && checks > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask
    task exp(input logic [6:1] p, input logic [31:0] c);
        notes.push_back({7'h00, p, c});
    endtask
    task wait_count(input logic [31:0] v);
        @(negedge sys_clk);
        for (int i = 0; i < 60 && countValue !== v; i++) @(negedge sys_clk);
        if (countValue !== v) begin
            failures++;
            finish_test();
        end
    endtask
    task put(input int idx, input logic [31:0] v, input logic rel);
        matchWrite = 7'h01 << idx;
        matchWriteData = v;
        @(negedge sys_clk);
        matchWrite = 7'h00;
        matchRelease = rel ? 7'h01 << idx : 7'h00;
        @(negedge sys_clk);
        matchRelease = 7'h00;
    endtask
    ////////////////////////////////////////////////////////////
    // clock and hang limit
    initial begin
        sys_clk = 1'b0;
        forever #10 sys_clk = ~sys_clk;
    end
    initial begin
        repeat (20000) @(posedge sys_clk);
        failures++;
        finish_test();
    end
    // scoreboard: every output change or event takes the oldest note
    initial begin
        logic [44:0] note;
        lastPulse = 6'h00;
        forever begin
            @(negedge sys_clk);
            if (rstn === 1'b1 && (pulseOut !== lastPulse || matchEvent !== 7'h00)) begin
                note = notes.size() ? notes.pop_front() : 45'h1;
                chk({matchEvent, pulseOut, countValue}, note, "outputs");
            end
            lastPulse = pulseOut;
        end
    end
    // stimulus
    initial begin
        seed = 96;
        {rstn, counterEnable, counterReset, pwmEnable, counterMode, slaveMode, masterRunning, spin} = 8'h20;
        {prescaleLimit, matchWriteData} = 64'h0;
        {matchWrite, matchRelease, matchResetEn, matchStopEn, matchEventEn} = 35'h0;
        {doubleEdgeSel, outputEnable, captureSelect, captureEdge} = 16'h0;
        tbl = '{32'h4, 32'h2, 32'h1, 32'h3, 32'h3, 32'h1};
        failures = 0;
        checks = 0;
        repeat (4) @(posedge sys_clk);
        @(negedge sys_clk);
        rstn = 1'b1;
        for (int i = 0; i < 6; i++) put(i, tbl[i], 1'b1);
        // outputs 3 and 5 double edge, 1 single edge
        doubleEdgeSel = 6'h14;
        outputEnable = 6'h15;
        {slaveMode, pwmEnable, counterEnable, counterReset} = 4'hE;
        repeat (5) @(negedge sys_clk);
        chk(45'({runningOut, countValue}), 45'h0, "slave count");
        $display("slave test done");
        for (int k = 0; k < 4; k++) begin
            exp(k % 3 ? 6'h05 : 6'h04, 32'h2);
            if (k % 3) exp(6'h04, 32'h3);
            exp(6'h10, 32'h4);
            exp(6'h11, 32'h0);
        end
        exp(6'h00, 32'h0);
        masterRunning = 1'b1;
        repeat (2) wait_count(32'h1);
        put(1, 32'h1, 1'b0);
        wait_count(32'h1);
        matchRelease = 7'h02;
        @(negedge sys_clk);
        matchRelease = 7'h00;
        repeat (2) wait_count(32'h1);
        {pwmEnable, counterEnable, counterReset} = 3'h1;
        repeat (3) @(negedge sys_clk);
        $display("pulse test done");
        // plain timer: random prescale, clear and stop on match 2
        prescaleLimit = 32'($random(seed) & 3);
        put(2, 32'($random(seed) & 7) + 32'h2, 1'b1);
        {matchResetEn, matchStopEn, matchEventEn} = {3{7'h04}};
        notes.push_back({7'h04, 6'h00, 32'h0});
        {counterEnable, counterReset} = 2'h2;
        for (int i = 0; i < 400 && counterStopped !== 1'b1; i++) @(negedge sys_clk);
        repeat (6) @(negedge sys_clk);
        chk(45'({counterStopped, countValue}), 45'h100000000, "stop");
        $display("timer test done");
        // counting rising edges of the tachometer
        {counterEnable, counterReset, counterMode, spin} = 4'h7;
        {matchResetEn, matchStopEn, matchEventEn, prescaleLimit} = 53'h0;
        @(negedge sys_clk);
        {counterEnable, counterReset} = 2'h2;
        repeat (80) @(negedge sys_clk);
        chk(45'(countValue >= 32'h8 && countValue <= 32'hB), 45'h1, "edge count");
        chk(45'(runningOut), 45'h1, "running");
        // counting both edges of the tachometer
        {counterEnable, counterReset, captureEdge} = 4'h7;
        @(negedge sys_clk);
        {counterEnable, counterReset} = 2'h2;
        repeat (80) @(negedge sys_clk);
        chk(45'(countValue >= 32'h12 && countValue <= 32'h15), 45'h1, "both edges");
        chk(45'(notes.size()), 45'h0, "notes left");
        $display("counter test done");
        finish_test();
    end
endmodule
